// file: design/drsis_pkg.sv
// Purpose: Shared constants for the reset sequencer and control-input qualifier
// Assumes: sys_clk_i at 50 MHz is the master (crystal-rate) clock
// Notes:   Cycle clock runs at one quarter of the master clock
package drsis_pkg;
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          CLK_DIV         = 4;
    localparam int          DIV_W           = 2;
    localparam logic [1:0]  DIV_RST         = 2'h0;
    localparam logic [1:0]  DIV_HALF        = 2'h1;
    localparam logic [1:0]  DIV_LAST        = 2'h3;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 16;
    localparam int          MIN_RST_CYC     = 5;
    localparam int          RESUME_CYC      = 1;
    localparam int          CLR_CYC         = 1;
    localparam int          CNT_W           = 3;
    localparam logic [2:0]  CNT_RST         = 3'h0;
    localparam logic [15:0] DATA_RST        = 16'h0000;
    localparam logic [11:0] ADDR_RST        = 12'h000;
endpackage

// file: design/drsis_sync_if.sv
// Purpose: Carrier for two-stage synchronised control levels
// Assumes: One clock domain
// Notes:   Only the second stage is visible to consumers
`timescale 1ns/1ns
interface drsis_sync_if;
    logic rst_n;
    logic intr_n;
    logic poll_n;
    modport src (output rst_n, output intr_n, output poll_n);
    modport dst (input rst_n, input intr_n, input poll_n);
endinterface

// file: design/drsis_sync.sv
// Purpose: Two flip-flop synchronisers for the external control pins
// Assumes: Pins are asynchronous to sys_clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module drsis_sync (
    input  wire logic   sys_clk_i,
    input  wire logic   rst_b_i,
    input  wire logic   reset_in_n_i,
    input  wire logic   intr_n_i,
    input  wire logic   branch_poll_input_n_i,
    drsis_sync_if.src   sy
);
    logic [2:0] s1_q;
    logic [2:0] s2_q;

    // =====================================================
    // Synchroniser stages
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
        end else begin
            s1_q <= {reset_in_n_i, intr_n_i, branch_poll_input_n_i};
            s2_q <= s1_q;
        end
    end

    assign sy.rst_n  = s2_q[2];
    assign sy.intr_n = s2_q[1];
    assign sy.poll_n = s2_q[0];
endmodule

// file: design/drsis_top.sv
// Purpose: Reset sequencing, bus parking and control-input qualification
// Assumes: sys_clk_i is the master clock; core requests are same-domain
// Notes:   Cycle clock is sys_clk_i divided by four
`timescale 1ns/1ns
// How it works
// RULE1 - While reset is low the read, write and fetch strobes are held high.
// RULE2 - While reset is low the sixteen data lines are not driven.
// RULE3 - Address outputs and program counter clear after the next full cycle of reset.
// RULE4 - The reset source holds reset low for at least five cycle-clock periods.
// RULE5 - Execution resumes one full cycle-clock period after reset is released.
// RULE6 - Reset may change at any time and is synchronised, so latency varies by a cycle.
// RULE7 - At most one of the read, write and fetch strobes is active at once.
// RULE8 - Outside logic must not trust a write address when reset hits mid-write.
// RULE9 - Outside logic holds the poll input for at least one cycle-clock period.
// RULE10 - The cycle clock runs at one quarter of the master clock.
// RULE11 - The read strobe enables peripheral data onto the bus for input transfers.
// RULE12 - Outside logic may pre-register asynchronous interrupt and poll inputs.
// RULE13 - Interrupt and poll are sampled once per cycle and only registered values act.
module drsis_top
    import drsis_pkg::*;
(
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       reset_in_n_i,
    input  wire logic                       intr_n_i,
    input  wire logic                       branch_poll_input_n_i,
    input  wire logic                       core_rd_req_i,
    input  wire logic                       core_wr_req_i,
    input  wire logic                       core_fetch_req_i,
    input  wire logic [drsis_pkg::DATA_W-1:0] core_wdata_i,
    input  wire logic [drsis_pkg::ADDR_W-1:0] core_addr_i,
    input  wire logic [drsis_pkg::DATA_W-1:0] data_in_i,
    output logic [drsis_pkg::DATA_W-1:0]    data_out_o,
    output logic                            data_oe_o,
    output logic [drsis_pkg::DATA_W-1:0]    core_rdata_o,
    output logic [drsis_pkg::ADDR_W-1:0]    address_outputs_o,
    output logic [drsis_pkg::ADDR_W-1:0]    pc_o,
    output logic                            input_read_strobe_n_o,
    output logic                            write_strobe_n_o,
    output logic                            program_fetch_strobe_n_o,
    output logic                            cycle_clock_out_o,
    output logic                            cycle_tick_o,
    output logic                            run_o,
    output logic                            intr_o,
    output logic                            branch_poll_o
);
    import drsis_pkg::*;

    typedef enum logic [1:0] {
        DRSIS_RUN,
        DRSIS_HOLD,
        DRSIS_CLEARED,
        DRSIS_RESUME
    } drsis_state_t;

    drsis_sync_if sy ();

    logic [DIV_W-1:0]  div_q;
    drsis_state_t      state_q;
    drsis_state_t      state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic              rs_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] pc_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic              rd_q;
    logic              wr_q;
    logic              fe_q;
    logic              oe_q;
    logic              intr_q;
    logic              poll_q;

    drsis_sync u_sync (
        .sys_clk_i             (sys_clk_i),
        .rst_b_i               (rst_b_i),
        .reset_in_n_i          (reset_in_n_i),
        .intr_n_i              (intr_n_i),
        .branch_poll_input_n_i (branch_poll_input_n_i),
        .sy                    (sy)
    );

    // ==========================================================
    // Cycle clock
    // RULE10 divide by four
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            div_q <= DIV_RST;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    wire tick     = (div_q == DIV_LAST);
    wire clk_high = (div_q < DIV_HALF + 2'h1);

    // ==========================================================
    // Reset sequencer, all steps on cycle boundaries
    wire in_rst   = !rs_q;
    wire running  = (state_q == DRSIS_RUN);
    wire cnt_done = (cnt_q == CNT_W'(RESUME_CYC - 1));

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            DRSIS_RUN: begin
                if (in_rst) begin
                    state_d = DRSIS_HOLD;
                    cnt_d   = CNT_RST;
                end
            end
            DRSIS_HOLD: begin
                // RULE3 clear after one full cycle
                if (cnt_q == CNT_W'(CLR_CYC - 1)) begin
                    state_d = DRSIS_CLEARED;
                end
                cnt_d = cnt_q + 3'h1;
            end
            DRSIS_CLEARED: begin
                if (!in_rst) begin
                    state_d = DRSIS_RESUME;
                    cnt_d   = CNT_RST;
                end
            end
            DRSIS_RESUME: begin
                // RULE5 resume after one cycle
                if (in_rst) begin
                    state_d = DRSIS_HOLD;
                    cnt_d   = CNT_RST;
                end else if (cnt_done) begin
                    state_d = DRSIS_RUN;
                end else begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
            default: begin
                state_d = DRSIS_HOLD;
                cnt_d   = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_q <= DRSIS_CLEARED;
            cnt_q   <= CNT_RST;
            rs_q    <= 1'b0;
        end else if (tick) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            // RULE6 synchronised reset sampled per cycle
            rs_q    <= sy.rst_n;
        end
    end

    // ==========================================================
    // Strobe and bus control
    // RULE7 one strobe at a time, read first
    wire go_rd = running && !in_rst && core_rd_req_i;
    wire go_wr = running && !in_rst && core_wr_req_i && !core_rd_req_i;
    wire go_fe = running && !in_rst && core_fetch_req_i && !core_rd_req_i
                 && !core_wr_req_i;
    wire clr   = (state_q == DRSIS_HOLD) && (state_d == DRSIS_CLEARED);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            fe_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (in_rst || !running) begin
            // RULE1 strobes inactive in reset
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            fe_q <= 1'b0;
            // RULE2 release data bus
            oe_q <= 1'b0;
        end else if (tick) begin
            rd_q <= go_rd;
            wr_q <= go_wr;
            fe_q <= go_fe;
            oe_q <= go_wr;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            addr_q  <= ADDR_RST;
            pc_q    <= ADDR_RST;
            wdata_q <= DATA_RST;
            rdata_q <= DATA_RST;
        end else if (tick) begin
            if (clr) begin
                // RULE3 synchronous clear
                addr_q <= ADDR_RST;
                pc_q   <= ADDR_RST;
            end else if (running && !in_rst && (go_rd || go_wr || go_fe)) begin
                addr_q <= core_addr_i;
                if (go_fe) begin
                    pc_q <= core_addr_i + 12'h001;
                end
            end
            if (go_wr) begin
                wdata_q <= core_wdata_i;
            end
            // RULE11 capture peripheral data under read or fetch strobe
            if (rd_q || fe_q) begin
                rdata_q <= data_in_i;
            end
        end
    end

    // ==========================================================
    // Interrupt and poll qualification
    // RULE13 sample once per cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            intr_q <= 1'b0;
            poll_q <= 1'b0;
        end else if (tick) begin
            intr_q <= !sy.intr_n;
            poll_q <= !sy.poll_n;
        end
    end

    assign cycle_clock_out_o        = clk_high;
    assign cycle_tick_o             = tick;
    assign run_o                    = running && !in_rst;
    assign input_read_strobe_n_o    = !rd_q;
    assign write_strobe_n_o         = !wr_q;
    assign program_fetch_strobe_n_o = !fe_q;
    assign data_oe_o                = oe_q;
    assign data_out_o               = wdata_q;
    assign core_rdata_o             = rdata_q;
    assign address_outputs_o        = addr_q;
    assign pc_o                     = pc_q;
    assign intr_o                   = intr_q;
    assign branch_poll_o            = poll_q;
endmodule

// file: test/drsis_props.sv
// Purpose: Port-level properties of the reset sequencer
// Assumes: Bound into drsis_top, one clock domain
// Notes:   Reset windows allow for pin sync and cycle-clock latency
`timescale 1ns/1ns
module drsis_props
    import drsis_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              rst_b_i,
    input wire logic              reset_in_n_i,
    input wire logic              branch_poll_input_n_i,
    input wire logic              core_rd_req_i,
    input wire logic [ADDR_W-1:0] core_addr_i,
    input wire logic              data_oe_o,
    input wire logic [ADDR_W-1:0] address_outputs_o,
    input wire logic [ADDR_W-1:0] pc_o,
    input wire logic              input_read_strobe_n_o,
    input wire logic              write_strobe_n_o,
    input wire logic              program_fetch_strobe_n_o,
    input wire logic              cycle_clock_out_o,
    input wire logic              cycle_tick_o,
    input wire logic              run_o,
    input wire logic              branch_poll_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic [2:0] strb_n = {program_fetch_strobe_n_o, write_strobe_n_o, input_read_strobe_n_o};
    sequence rs_held; !reset_in_n_i[*8]; endsequence
    sequence poll_held; !branch_poll_input_n_i[*8]; endsequence
    sequence quarter; cycle_clock_out_o[*2] ##1 !cycle_clock_out_o[*2]; endsequence
    // Pin sync, one tick to see it, one full cycle in resume
    sequence resume_wait; !run_o[*8] ##1 !run_o[*3]; endsequence
    // ==========
    // Properties
    chk_strobe_mutex: assert property ($onehot0(~strb_n))
        else $error("strobes overlap");
    chk_rs_parks: assert property (rs_held |-> &strb_n)
        else $error("strobe active in reset");
    chk_rs_float: assert property (rs_held |-> !data_oe_o)
        else $error("bus driven in reset");
    chk_addr_clear: assert property (rs_held |-> ##[0:8] !(|{address_outputs_o, pc_o}))
        else $error("address not cleared");
    chk_rs_halt: assert property (rs_held |-> !run_o)
        else $error("running in reset");
    chk_resume_time: assert property ($rose(reset_in_n_i) |-> resume_wait ##[1:4] run_o)
        else $error("resume time wrong");
    chk_quarter_clk: assert property (cycle_tick_o |=> quarter ##0 cycle_tick_o)
        else $error("cycle clock not quarter rate");
    chk_read_strobe: assert property (cycle_tick_o && run_o && core_rd_req_i |=>
        address_outputs_o == $past(core_addr_i) ##0 !input_read_strobe_n_o[*4])
        else $error("read strobe wrong");
    chk_poll_qual: assert property (poll_held |-> ##[0:4] branch_poll_o)
        else $error("poll not qualified");
endmodule
bind drsis_top drsis_props u_props (.*);

// file: test/drsis_partner.sv
// Purpose: Memory, peripheral and pin registers beside the sequencer
// Assumes: Same master clock as the sequencer
// Notes:   Undriven bus toggles so stale data never passes
`timescale 1ns/1ns
module drsis_partner
    import drsis_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              cycle_clock_out_i,
    input  wire logic [ADDR_W-1:0] address_i,
    input  wire logic              rd_strobe_n_i,
    input  wire logic              fetch_strobe_n_i,
    input  wire logic              poll_raw_n_i,
    input  wire logic              intr_raw_n_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   poll_n_o = 1'b1,
    output logic                   intr_n_o = 1'b1
);
    logic [DATA_W-1:0] last_q = DATA_RST;
    assign data_o = (rd_strobe_n_i && fetch_strobe_n_i) ? ~last_q : {4'hA, address_i};
    always @(posedge sys_clk_i) last_q <= data_o;
    always @(posedge cycle_clock_out_i) {poll_n_o, intr_n_o} <= {poll_raw_n_i, intr_raw_n_i};
endmodule

// file: test/tb_dsp_reset_and_input_sync.sv
// Purpose: Self-checking bench for drsis_top
// Assumes: Partner answers reads with 4'hA and the address
// Notes:   Reset pin held the minimum five cycle periods
`timescale 1ns/1ns
module tb_dsp_reset_and_input_sync;
    import drsis_pkg::*;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, reset_in_n_i = 1'b0, poll_raw_n = 1'b1;
    logic intr_raw_n = 1'b1, core_rd_req_i = 1'b0, core_wr_req_i = 1'b0, core_fetch_req_i = 1'b0;
    logic [DATA_W-1:0] core_wdata_i = DATA_RST, data_in_i, data_out_o, core_rdata_o;
    logic [ADDR_W-1:0] core_addr_i = ADDR_RST, address_outputs_o, pc_o;
    logic intr_n_i, branch_poll_input_n_i, data_oe_o, input_read_strobe_n_o, write_strobe_n_o;
    logic program_fetch_strobe_n_o, cycle_clock_out_o, cycle_tick_o, run_o, intr_o, branch_poll_o;
    int failures = 0, samples_checked = 0;
    drsis_top dut (.*);
    drsis_partner mem (.sys_clk_i, .cycle_clock_out_i(cycle_clock_out_o),
        .address_i(address_outputs_o), .rd_strobe_n_i(input_read_strobe_n_o),
        .fetch_strobe_n_i(program_fetch_strobe_n_o), .poll_raw_n_i(poll_raw_n),
        .intr_raw_n_i(intr_raw_n), .data_o(data_in_i), .poll_n_o(branch_poll_input_n_i),
        .intr_n_o(intr_n_i));
    // ==========
    // Tasks
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rs_pulse();
        int n;
        @(posedge sys_clk_i) reset_in_n_i <= 1'b0;
        repeat (MIN_RST_CYC * CLK_DIV) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(&{input_read_strobe_n_o, write_strobe_n_o, program_fetch_strobe_n_o}, "park");
        check(data_oe_o === 1'b0, "bus driven");
        check(address_outputs_o === ADDR_RST && pc_o === ADDR_RST, "clear");
        check(run_o === 1'b0, "halt");
        @(posedge sys_clk_i) {reset_in_n_i, core_wr_req_i} <= 2'h2;
        for (n = 0; run_o !== 1'b1 && n < 20; n++) @(negedge sys_clk_i);
        check(n >= 12 && n <= 15, "resume");
        $display("reset pulse done");
    endtask
    task automatic xfer(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        logic [2:0] e;
        e = ~(3'h1 << k);
        n = 0;
        @(posedge sys_clk_i) {core_fetch_req_i, core_wr_req_i, core_rd_req_i} <= ~e;
        core_addr_i <= a;
        core_wdata_i <= d;
        do @(negedge sys_clk_i); while (!(cycle_tick_o && run_o) && ++n < 16);
        check(n < 16, "request not taken");
        @(posedge sys_clk_i) {core_fetch_req_i, core_wr_req_i, core_rd_req_i} <= 3'h0;
        repeat (4) begin
            @(negedge sys_clk_i);
            check({program_fetch_strobe_n_o, write_strobe_n_o, input_read_strobe_n_o} === e, "strobe");
            check(address_outputs_o === a && data_oe_o === (k == 1), "addr");
            if (k == 1) check(data_out_o === d, "wdata");
        end
        @(negedge sys_clk_i);
        check(&{program_fetch_strobe_n_o, write_strobe_n_o, input_read_strobe_n_o}, "idle");
        if (k != 1) check(core_rdata_o === {4'hA, a}, "rdata");
        if (k == 2) check(pc_o === a + 12'h001, "pc");
        $display("transfer %0d done", k);
    endtask
    task automatic poll_test();
        int n;
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk_i) {poll_raw_n, intr_raw_n} <= {2{v[0]}};
            for (n = 0; {branch_poll_o, intr_o} !== {2{~v[0]}} && n < 16; n++) @(negedge sys_clk_i);
            check(n < 16, "qualify");
        end
        $display("poll test done");
    endtask
    initial forever #10 sys_clk_i = ~sys_clk_i;
    // Whole run needs under 400 clocks
    initial begin
        #(1000 * 20);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rs_pulse();
        xfer(0, 12'hFFF, DATA_RST);
        xfer(1, 12'h000, 16'hA5C3);
        xfer(2, 12'h800, DATA_RST);
        poll_test();
        @(posedge sys_clk_i) core_wr_req_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        rs_pulse();
        xfer(0, 12'h123, DATA_RST);
        print_verdict();
    end
endmodule
